// file: sim/psgar_eeprom_model.sv
// eeprom engine model: takes the save stream and replays it on restore
`timescale 1ns/1ps
module psgar_eeprom_model
   import psgar_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic slow,
   input wire psgar_word_s save_word,
   output logic save_ready,
   input wire logic restore_request,
   output psgar_word_s restore_word
);
   logic [7:0][27:0] mem;
   logic [3:0] cnt;
   logic ph = 1'b0;
   // ---------------------------------------------------------------
   // boot image and save capture
   // ---------------------------------------------------------------
   // image survives reset, as the real part keeps it across power-down
   initial begin
      for (int i = 0; i < 8; i++) mem[i] = {i[3:0], 24'h5a5a5a};
   end
   // slow mode stalls every other cycle
   assign save_ready = !slow | ph;
   always @(posedge mclk) begin
      ph <= !ph;
      if (save_word.valid && save_ready) mem[save_word.index] <= save_word.data;
   end
   // ---------------------------------------------------------------
   // restore replay
   // ---------------------------------------------------------------
   // one word per ready cycle; idle data lines flip so stale data never matches
   always @(posedge mclk) begin
      if (reset) begin
         cnt <= 4'h0;
         restore_word <= '0;
      end else if (restore_request && cnt < 4'h8 && save_ready) begin
         restore_word <= {1'b1, cnt[2:0], mem[cnt[2:0]]};
         cnt <= cnt + 4'h1;
      end else begin
         restore_word.valid <= 1'b0;
         restore_word.data <= ~restore_word.data;
      end
   end
endmodule // psgar_eeprom_model

// file: sim/tb_psgar_regs.sv
// self-checking bench for the save slot, pin level and aux result bank
`timescale 1ns/1ps
module tb_psgar_regs
   import psgar_pkg::*;
;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic reg_wr_en = 1'b0, reg_rd_en = 1'b0, reg_rd_valid;
   logic [15:0] reg_addr = 16'h0000;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, rd;
   logic ov_slot = 1'b0, ov_pin = 1'b0, ov_aux = 1'b0;
   psgar_core_s core_update = '0;
   psgar_conv_s conv_sample = '0;
   logic [11:0] pin_in = 12'h000, pin_lvl, acc;
   logic [3:0][27:0] aux_word;
   logic trig = 1'b0, edge_rise = 1'b1, slow = 1'b0;
   logic save_start, save_ready, restore_request;
   psgar_word_s save_word, restore_word;
   psgar_cfg_s cfg;
   int num_errors = 0, tests_run = 0, cyc = 0;
   logic [27:0] exp_s [8];
   logic [7:0] kk [4];
   logic [15:0] ra [11] = '{16'h0808, 16'h0809, 16'h080c, 16'h0820, 16'h0821, 16'h0822,
      16'h0824, 16'h0826, 16'h0827, 16'h080d, 16'h0823};
   logic [31:0] msk [11] = '{32'h0, 32'h0, 32'h0, 32'hffffff, 32'hffffff, 32'h3ef,
      32'h8000, 32'h4, 32'h3, 32'h0, 32'h0};

   psgar_regs dut_u (.mclk(mclk), .reset(reset), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rd_valid(reg_rd_valid), .host_override_param_slots(ov_slot),
      .host_override_pin_levels(ov_pin), .host_override_aux_results(ov_aux),
      .core_update(core_update), .multipurpose_pin_in(pin_in),
      .multipurpose_pin_levels(pin_lvl), .conv_sample(conv_sample), .aux_param_word(aux_word),
      .save_trigger_pin(trig), .save_edge_rising(edge_rise), .save_start(save_start),
      .save_word(save_word), .save_ready(save_ready), .restore_word(restore_word),
      .restore_request(restore_request), .cfg(cfg));
   psgar_eeprom_model em_u (.mclk(mclk), .reset(reset), .slow(slow), .save_word(save_word),
      .save_ready(save_ready), .restore_request(restore_request), .restore_word(restore_word));

   // ---------------------------------------------------------------
   // clock, hang guard and helpers
   // ---------------------------------------------------------------
   initial forever #5 mclk = ~mclk;
   // whole run is a few hundred cycles; the ceiling of 20000 leaves ample room
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         end_sim();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_wr_en <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr_en <= 1'b0;
   endtask
   // read data arrives one cycle after the strobe is taken
   task automatic rdc(input logic [15:0] a, input logic [31:0] e);
      @(posedge mclk);
      reg_rd_en <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd_en <= 1'b0;
      #1;
      chk({31'h0, reg_rd_valid}, 32'h1);
      chk(reg_rdata, e);
   endtask
   task automatic tick();
      @(posedge mclk);
      core_update.frame_tick <= 1'b1;
      @(posedge mclk);
      core_update.frame_tick <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask
   task automatic conv(input logic [1:0] c, input logic [7:0] k);
      @(posedge mclk);
      conv_sample <= {1'b1, c, k};
      @(posedge mclk);
      conv_sample.valid <= 1'b0;
      @(posedge mclk);
   endtask
   function automatic logic [11:0] scl(input logic [11:0] x);
      return (x >= 12'hff0) ? 12'h800 : (x >> 1) + (x >> 9);
   endfunction
   // trigger idles at the opposite level first, so that edge must be ignored
   task automatic save(input logic p);
      @(posedge mclk);
      edge_rise <= p;
      trig <= ~p;
      repeat (8) @(posedge mclk);
      trig <= p;
      rd = 32'h0;
      for (int i = 0; i < 12 && rd == 32'h0; i++) begin
         @(posedge mclk);
         #1;
         rd = {31'h0, save_start};
      end
      chk(rd, 32'h1);
      repeat (40) @(posedge mclk);
      for (int i = 0; i < 8; i++) chk({4'h0, em_u.mem[i]}, {4'h0, exp_s[i]});
   endtask
   task automatic boot();
      for (int w = 0; w < 60 && restore_request !== 1'b0; w++) begin
         @(posedge mclk);
         #1;
      end
      chk({31'h0, restore_request}, 32'h0);
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      void'($urandom(35));
      repeat (10) @(posedge mclk);
      reset <= 1'b0;
      boot();
      for (int i = 0; i < 8; i++) rdc(ADDR_SLOT_FIRST + 16'(i), {8'(i), 24'h5a5a5a});
      // reset values, then random writes checked against the masks incl. refused and unmapped places
      for (int i = 0; i < 11; i++) rdc(ra[i], 32'h0);
      for (int i = 0; i < 11; i++) begin
         rd = $urandom;
         wr(ra[i], rd);
         rdc(ra[i], rd & msk[i]);
      end
      $display("test registers done");
      @(posedge mclk);
      for (int i = 0; i < 8; i++) core_update.param[i] <= 28'($urandom);
      tick();
      wr(ADDR_SLOT_FIRST, 32'hffffffff);
      for (int i = 0; i < 8; i++) rdc(ADDR_SLOT_FIRST + 16'(i), {4'h0, core_update.param[i]});
      @(posedge mclk);
      ov_slot <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         rd = $urandom;
         exp_s[i] = rd[27:0];
         wr(ADDR_SLOT_FIRST + 16'(i), rd);
      end
      core_update.param <= ~core_update.param;
      tick();
      for (int i = 0; i < 8; i++) rdc(ADDR_SLOT_FIRST + 16'(i), {4'h0, exp_s[i]});
      $display("test slots done");
      save(1'b1);
      exp_s[7] = 28'($urandom);
      wr(ADDR_SLOT_LAST, {4'hf, exp_s[7]});
      slow <= 1'b1;
      save(1'b0);
      @(posedge mclk);
      reset <= 1'b1;
      repeat (3) @(posedge mclk);
      reset <= 1'b0;
      boot();
      for (int i = 0; i < 8; i++) rdc(ADDR_SLOT_FIRST + 16'(i), {4'h0, exp_s[i]});
      $display("test save and restore done");
      @(posedge mclk);
      pin_in <= 12'($urandom);
      repeat (8) @(posedge mclk);
      tick();
      chk({20'h0, pin_lvl}, {20'h0, pin_in});
      rdc(ADDR_PIN_LEVELS, {20'h0, pin_in});
      @(posedge mclk);
      ov_pin <= 1'b1;
      rd = $urandom;
      wr(ADDR_PIN_LEVELS, rd);
      pin_in <= ~pin_in;
      repeat (8) @(posedge mclk);
      tick();
      rdc(ADDR_PIN_LEVELS, {20'h0, rd[11:0]});
      $display("test pins done");
      wr(ADDR_AUX_PWR, 32'h0);
      wr(ADDR_AUX_EN, 32'h8000);
      for (int c = 0; c < 4; c++) begin
         kk[c] = (c == 0) ? 8'hff : 8'($urandom);
         conv(2'(c), kk[c]);
         rdc(ADDR_AUX_FIRST + 16'(c), {20'h0, kk[c], 4'h0});
         chk({4'h0, aux_word[c]}, {8'h0, scl({kk[c], 4'h0}), 12'h000});
      end
      // filtered mode: one step of the smoothing toward full scale
      wr(ADDR_AUX_PWR, 32'h100);
      acc = {kk[2], 4'h0};
      conv(2'h2, 8'hff);
      acc = acc + ((12'hff0 - acc) >> 1);
      rdc(ADDR_AUX_FIRST + 16'h2, {20'h0, acc});
      // deepest smoothing, decaying toward zero: the step rounds toward minus infinity
      wr(ADDR_AUX_PWR, 32'h300);
      #1;
      chk({16'h0, cfg.aux_pwr}, 32'h300);
      conv(2'h2, 8'h00);
      acc = acc - ((acc + 12'h007) >> 3);
      rdc(ADDR_AUX_FIRST + 16'h2, {20'h0, acc});
      // converter disabled: a sample must leave the result alone
      wr(ADDR_AUX_EN, 32'h0);
      conv(2'h1, 8'($urandom));
      rdc(ADDR_AUX_FIRST + 16'h1, {20'h0, kk[1], 4'h0});
      wr(ADDR_AUX_EN, 32'h8000);
      @(posedge mclk);
      ov_aux <= 1'b1;
      wr(ADDR_AUX_FIRST, 32'hfffffabc);
      conv(2'h0, 8'h12);
      rdc(ADDR_AUX_FIRST, 32'h00000abc);
      $display("test aux results done");
      end_sim();
   end
endmodule // tb_psgar_regs

// file: verilog/psgar_pkg.sv
// package: map, field layout and carriers of the parameter-save / pin / aux-result bank
package psgar_pkg;
   // ---------------------------------------------------------------
   // register offsets on the control port (register numbers)
   // ---------------------------------------------------------------
   localparam logic [15:0] ADDR_SLOT_FIRST = 16'h0800;
   localparam logic [15:0] ADDR_SLOT_LAST = 16'h0807;
   localparam logic [15:0] ADDR_PIN_LEVELS = 16'h0808;
   localparam logic [15:0] ADDR_AUX_FIRST = 16'h0809;
   localparam logic [15:0] ADDR_AUX_LAST = 16'h080c;
   localparam logic [15:0] ADDR_MP_CFG_LOW = 16'h0820;
   localparam logic [15:0] ADDR_MP_CFG_HIGH = 16'h0821;
   localparam logic [15:0] ADDR_AUX_PWR = 16'h0822;
   localparam logic [15:0] ADDR_RSVD_A = 16'h0823;
   localparam logic [15:0] ADDR_AUX_EN = 16'h0824;
   localparam logic [15:0] ADDR_RSVD_B = 16'h0825;
   localparam logic [15:0] ADDR_OSC_PD = 16'h0826;
   localparam logic [15:0] ADDR_DAC_SETUP = 16'h0827;
   // ---------------------------------------------------------------
   // field layout and storage masks
   // ---------------------------------------------------------------
   localparam int PARAM_W = 28;
   localparam int PIN_W = 12;
   localparam int AUX_W = 12;
   localparam int N_SLOTS = 8;
   localparam int N_AUX = 4;
   localparam int FIL_POS = 8;
   localparam int AUX_EN_POS = 15;
   localparam logic [15:0] AUX_PWR_MASK = 16'h03ef;
   localparam logic [15:0] AUX_EN_MASK = 16'h8000;
   localparam logic [15:0] OSC_PD_MASK = 16'h0004;
   localparam logic [15:0] DAC_SETUP_MASK = 16'h0003;
   localparam logic [11:0] AUX_FULL_SCALE = 12'hff0;
   localparam logic [11:0] AUX_UNITY = 12'h800;
   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [27:0] RST_SLOT = 28'h0000000;
   localparam logic [15:0] RST_REG16 = 16'h0000;
   localparam logic [23:0] RST_REG24 = 24'h000000;
   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef enum logic {SV_IDLE, SV_SEND} psgar_save_e;
   typedef struct packed {
      logic frame_tick;
      logic [7:0][27:0] param;
   } psgar_core_s;
   typedef struct packed {
      logic valid;
      logic [1:0] chan;
      logic [7:0] code;
   } psgar_conv_s;
   typedef struct packed {
      logic valid;
      logic [2:0] index;
      logic [27:0] data;
   } psgar_word_s;
   typedef struct packed {
      logic [23:0] mp_cfg_low;
      logic [23:0] mp_cfg_high;
      logic [15:0] aux_pwr;
      logic [15:0] aux_en;
      logic [15:0] osc_pd;
      logic [15:0] dac_setup;
   } psgar_cfg_s;
   typedef struct packed {
      logic [7:0][27:0] slot;
      logic [7:0][27:0] snap;
      logic [11:0] pins;
      logic [2:0][11:0] pin_sync;
      logic [11:0] pin_lvl;
      logic [3:0][11:0] aux;
      logic [3:0][11:0] aux_scaled;
      logic [2:0] trig_sync;
      logic trig_lvl;
      psgar_save_e save_state;
      logic save_start;
      psgar_word_s save_out;
      logic restore_req;
      psgar_cfg_s cfg;
      logic [31:0] rdata;
      logic rd_valid;
   } psgar_state_s;
endpackage

// file: verilog/psgar_regs.sv
// parameter save slots, pin level register and aux converter results behind the control port
`timescale 1ns/1ps
module psgar_regs
   import psgar_pkg::*;
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic reg_wr_en,
   input wire logic reg_rd_en,
   input wire logic [15:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   output logic reg_rd_valid,
   input wire logic host_override_param_slots,
   input wire logic host_override_pin_levels,
   input wire logic host_override_aux_results,
   input wire psgar_core_s core_update,
   input wire logic [11:0] multipurpose_pin_in,
   output logic [11:0] multipurpose_pin_levels,
   input wire psgar_conv_s conv_sample,
   output logic [3:0][27:0] aux_param_word,
   input wire logic save_trigger_pin,
   input wire logic save_edge_rising,
   output logic save_start,
   output psgar_word_s save_word,
   input wire logic save_ready,
   input wire psgar_word_s restore_word,
   output logic restore_request,
   output psgar_cfg_s cfg
);
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic in_range(logic [15:0] a, logic [15:0] lo, logic [15:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   // map the stored 12-bit result to 1.11; saturate so full scale is exact unity
   function automatic logic [11:0] aux_scale(logic [11:0] x);
      if (x >= AUX_FULL_SCALE) begin
         aux_scale = AUX_UNITY;
      end else begin
         aux_scale = (x >> 1) + (x >> 9);
      end
   endfunction

   // one-pole smoother; select 0 passes the raw 8-bit code
   function automatic logic [11:0] aux_filter(logic [11:0] acc, logic [7:0] code,
                                             logic [1:0] sel);
      logic signed [12:0] diff;
      logic signed [12:0] step;
      logic [12:0] sum;
      diff = $signed({1'b0, code, 4'h0}) - $signed({1'b0, acc});
      step = diff >>> sel;
      sum = {1'b0, acc} + 13'(step);
      if (sel == 2'b00) begin
         aux_filter = {code, 4'h0};
      end else begin
         aux_filter = sum[11:0];
      end
   endfunction

   function automatic logic [31:0] read_word(psgar_state_s s, logic [15:0] a);
      logic [15:0] off;
      off = a - ADDR_SLOT_FIRST;
      read_word = 32'h00000000;
      if (in_range(a, ADDR_SLOT_FIRST, ADDR_SLOT_LAST)) begin
         read_word = {4'h0, s.slot[off[2:0]]};
      end else if (a == ADDR_PIN_LEVELS) begin
         read_word = {20'h00000, s.pins};
      end else if (in_range(a, ADDR_AUX_FIRST, ADDR_AUX_LAST)) begin
         read_word = {20'h00000, s.aux[2'(a - ADDR_AUX_FIRST)]};
      end else if (a == ADDR_MP_CFG_LOW) begin
         read_word = {8'h00, s.cfg.mp_cfg_low};
      end else if (a == ADDR_MP_CFG_HIGH) begin
         read_word = {8'h00, s.cfg.mp_cfg_high};
      end else if (a == ADDR_AUX_PWR) begin
         read_word = {16'h0000, s.cfg.aux_pwr};
      end else if (a == ADDR_AUX_EN) begin
         read_word = {16'h0000, s.cfg.aux_en};
      end else if (a == ADDR_OSC_PD) begin
         read_word = {16'h0000, s.cfg.osc_pd};
      end else if (a == ADDR_DAC_SETUP) begin
         read_word = {16'h0000, s.cfg.dac_setup};
      end
   endfunction

   psgar_state_s st;
   psgar_state_s next_st;
   logic trig_edge;
   logic [15:0] slot_off;
   logic [15:0] aux_off;

   assign slot_off = reg_addr - ADDR_SLOT_FIRST;
   assign aux_off = reg_addr - ADDR_AUX_FIRST;
   // ---------------------------------------------------------------
   // next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      next_st = st;
      trig_edge = 1'b0;
      // read answers one cycle after the strobe; reserved space reads zero
      next_st.rd_valid = reg_rd_en;
      if (reg_rd_en) begin
         next_st.rdata = read_word(st, reg_addr);
      end
      // pin and trigger synchronisers: a change counts once stages two and three agree
      next_st.pin_sync = {st.pin_sync[1:0], multipurpose_pin_in};
      next_st.pin_lvl = (st.pin_sync[1] & ~(st.pin_sync[1] ^ st.pin_sync[2]))
                      | (st.pin_lvl & (st.pin_sync[1] ^ st.pin_sync[2]));
      next_st.trig_sync = {st.trig_sync[1:0], save_trigger_pin};
      if (st.trig_sync[1] == st.trig_sync[2]) begin
         next_st.trig_lvl = st.trig_sync[1];
      end
      // no save while the restore runs: the level settling after reset is not an edge
      trig_edge = (next_st.trig_lvl != st.trig_lvl) && (next_st.trig_lvl == save_edge_rising)
                  && !st.restore_req;
      // slots follow the core each sample period unless the host owns them
      if (!host_override_param_slots && core_update.frame_tick) begin
         next_st.slot = core_update.param;
      end
      if (reg_wr_en && host_override_param_slots
          && in_range(reg_addr, ADDR_SLOT_FIRST, ADDR_SLOT_LAST)) begin
         next_st.slot[slot_off[2:0]] = reg_wdata[27:0];
      end
      // restore from EEPROM wins, since it replays settings saved before power-down
      if (restore_word.valid) begin
         next_st.slot[restore_word.index] = restore_word.data;
         if (restore_word.index == 3'd7) begin
            next_st.restore_req = 1'b0;
         end
      end
      // pin register: host-owned under override, else sampled pins once per frame
      if (host_override_pin_levels) begin
         if (reg_wr_en && reg_addr == ADDR_PIN_LEVELS) begin
            next_st.pins = reg_wdata[11:0];
         end
      end else if (core_update.frame_tick) begin
         next_st.pins = st.pin_lvl;
      end
      // aux results: converter updates unless the host owns them
      if (host_override_aux_results) begin
         if (reg_wr_en && in_range(reg_addr, ADDR_AUX_FIRST, ADDR_AUX_LAST)) begin
            next_st.aux[aux_off[1:0]] = reg_wdata[11:0];
         end
      end else if (conv_sample.valid && st.cfg.aux_en[AUX_EN_POS]) begin
         next_st.aux[conv_sample.chan] = aux_filter(st.aux[conv_sample.chan],
            conv_sample.code, st.cfg.aux_pwr[FIL_POS+1:FIL_POS]);
      end
      for (int i = 0; i < N_AUX; i++) begin
         next_st.aux_scaled[i] = aux_scale(next_st.aux[i]);
      end
      // configuration words keep only their defined bits
      if (reg_wr_en) begin
         unique case (reg_addr)
            ADDR_MP_CFG_LOW: next_st.cfg.mp_cfg_low = reg_wdata[23:0];
            ADDR_MP_CFG_HIGH: next_st.cfg.mp_cfg_high = reg_wdata[23:0];
            ADDR_AUX_PWR: next_st.cfg.aux_pwr = reg_wdata[15:0] & AUX_PWR_MASK;
            ADDR_AUX_EN: next_st.cfg.aux_en = reg_wdata[15:0] & AUX_EN_MASK;
            ADDR_OSC_PD: next_st.cfg.osc_pd = reg_wdata[15:0] & OSC_PD_MASK;
            ADDR_DAC_SETUP: next_st.cfg.dac_setup = reg_wdata[15:0] & DAC_SETUP_MASK;
            default: next_st.cfg = st.cfg; // reserved and other addresses ignored
         endcase
      end
      // save stream: snapshot on the edge so later core updates cannot tear the set
      next_st.save_start = 1'b0;
      unique case (st.save_state)
         SV_IDLE: begin
            if (trig_edge) begin
               next_st.snap = st.slot;
               next_st.save_start = 1'b1;
               next_st.save_out = '{valid: 1'b1, index: 3'd0, data: st.slot[0]};
               next_st.save_state = SV_SEND;
            end
         end
         SV_SEND: begin
            // edges during a save are dropped; the stream is never restarted mid-way
            if (save_ready) begin
               if (st.save_out.index == 3'd7) begin
                  next_st.save_out.valid = 1'b0;
                  next_st.save_state = SV_IDLE;
               end else begin
                  next_st.save_out.index = st.save_out.index + 3'd1;
                  next_st.save_out.data = st.snap[st.save_out.index + 3'd1];
               end
            end
         end
      endcase
   end

   // state register
   always_ff @(posedge mclk) begin
      if (reset) begin
         st <= '0;
         st.restore_req <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign reg_rdata = st.rdata;
   assign reg_rd_valid = st.rd_valid;
   assign multipurpose_pin_levels = st.pins;
   assign save_start = st.save_start;
   assign save_word = st.save_out;
   assign restore_request = st.restore_req;
   assign cfg = st.cfg;
   // 5.23 word: four zero msbs, 1.11 value, twelve zero lsbs
   always_comb begin
      for (int i = 0; i < N_AUX; i++) begin
         aux_param_word[i] = {4'h0, st.aux_scaled[i], 12'h000};
      end
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   sequence s_read_at(logic [15:0] a);
      reg_rd_en && reg_addr == a ##1 1'b1;
   endsequence

   sequence s_save_opened;
      save_start && save_word.valid && save_word.index == 3'd0;
   endsequence

   property p_slot_top_zero;
      @(posedge mclk) disable iff (reset)
      s_read_at(ADDR_SLOT_FIRST) |-> reg_rd_valid && reg_rdata[31:28] == 4'h0;
   endproperty
   a_slot_top_zero: assert property (p_slot_top_zero)
      else $error("slot read shows nonzero top bits");

   property p_frame_refresh;
      @(posedge mclk) disable iff (reset)
      core_update.frame_tick && !host_override_param_slots && !restore_word.valid
      |=> st.slot[3] == $past(core_update.param[3]);
   endproperty
   a_frame_refresh: assert property (p_frame_refresh)
      else $error("slot did not follow the core on the frame tick");

   property p_save_on_edge;
      @(posedge mclk) disable iff (reset)
      $changed(st.trig_lvl) && st.trig_lvl == $past(save_edge_rising)
      && $past(st.save_state) == SV_IDLE && !$past(st.restore_req) |-> s_save_opened;
   endproperty
   a_save_on_edge: assert property (p_save_on_edge)
      else $error("trigger edge did not open a save");

   property p_save_stream;
      @(posedge mclk) disable iff (reset)
      s_save_opened ##0 save_ready |=> save_word.valid && save_word.index == 3'd1
      && save_word.data == st.snap[1];
   endproperty
   a_save_stream: assert property (p_save_stream)
      else $error("save stream did not advance to the second slot");

   property p_restore;
      @(posedge mclk) disable iff (reset)
      restore_word.valid |=> st.slot[$past(restore_word.index)] == $past(restore_word.data);
   endproperty
   a_restore: assert property (p_restore)
      else $error("restored word not taken into its slot");

   property p_host_slot_blocked;
      @(posedge mclk) disable iff (reset)
      reg_wr_en && reg_addr == ADDR_SLOT_FIRST && !host_override_param_slots
      && !core_update.frame_tick && !restore_word.valid |=> $stable(st.slot[0]);
   endproperty
   a_host_slot_blocked: assert property (p_host_slot_blocked)
      else $error("slot took a host write without override");

   property p_pin_write;
      @(posedge mclk) disable iff (reset)
      reg_wr_en && reg_addr == ADDR_PIN_LEVELS && host_override_pin_levels
      |=> multipurpose_pin_levels == $past(reg_wdata[11:0]);
   endproperty
   a_pin_write: assert property (p_pin_write)
      else $error("pin register missed a host write");

   property p_pin_hold;
      @(posedge mclk) disable iff (reset)
      !host_override_pin_levels && !core_update.frame_tick |=> $stable(multipurpose_pin_levels);
   endproperty
   a_pin_hold: assert property (p_pin_hold)
      else $error("pin register changed outside a frame tick");

   property p_pin_upper_zero;
      @(posedge mclk) disable iff (reset)
      s_read_at(ADDR_PIN_LEVELS) |-> reg_rdata[31:12] == 20'h00000;
   endproperty
   a_pin_upper_zero: assert property (p_pin_upper_zero)
      else $error("pin register upper bits not zero");

   property p_aux_unity;
      @(posedge mclk) disable iff (reset)
      st.aux[0] == AUX_FULL_SCALE |-> aux_param_word[0] == {4'h0, AUX_UNITY, 12'h000};
   endproperty
   a_aux_unity: assert property (p_aux_unity)
      else $error("full-scale result is not unity");

   property p_aux_host_only;
      @(posedge mclk) disable iff (reset)
      host_override_aux_results && !reg_wr_en |=> $stable(st.aux);
   endproperty
   a_aux_host_only: assert property (p_aux_host_only)
      else $error("aux result moved under host override");

   property p_rsvd_zero;
      @(posedge mclk) disable iff (reset)
      s_read_at(ADDR_RSVD_A) |-> reg_rdata == 32'h00000000;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero)
      else $error("reserved location read nonzero");

   property p_restore_done;
      @(posedge mclk) disable iff (reset)
      restore_word.valid && restore_word.index == 3'd7 |=> !restore_request;
   endproperty
   a_restore_done: assert property (p_restore_done)
      else $error("restore request still raised after the last word");

   property p_slot_host_write;
      @(posedge mclk) disable iff (reset)
      reg_wr_en && reg_addr == ADDR_SLOT_LAST && host_override_param_slots
      && !restore_word.valid |=> st.slot[7] == $past(reg_wdata[27:0]);
   endproperty
   a_slot_host_write: assert property (p_slot_host_write)
      else $error("host write did not land in the slot field");

   property p_aux_disabled;
      @(posedge mclk) disable iff (reset)
      conv_sample.valid && !host_override_aux_results && !st.cfg.aux_en[AUX_EN_POS]
      |=> $stable(st.aux);
   endproperty
   a_aux_disabled: assert property (p_aux_disabled)
      else $error("aux result moved while the converter is disabled");

   property p_aux_raw;
      @(posedge mclk) disable iff (reset)
      conv_sample.valid && !host_override_aux_results && st.cfg.aux_en[AUX_EN_POS]
      && st.cfg.aux_pwr[FIL_POS+1:FIL_POS] == 2'b00
      |=> st.aux[$past(conv_sample.chan)] == {$past(conv_sample.code), 4'h0};
   endproperty
   a_aux_raw: assert property (p_aux_raw)
      else $error("unfiltered result is not the code in the top eight bits");

   property p_aux_read;
      @(posedge mclk) disable iff (reset)
      s_read_at(ADDR_AUX_FIRST) |-> reg_rdata == {20'h00000, $past(st.aux[0])};
   endproperty
   a_aux_read: assert property (p_aux_read)
      else $error("aux result read does not match the stored value");

   property p_cfg_mask;
      @(posedge mclk) disable iff (reset)
      reg_wr_en && reg_addr == ADDR_AUX_PWR
      |=> cfg.aux_pwr == ($past(reg_wdata[15:0]) & AUX_PWR_MASK);
   endproperty
   a_cfg_mask: assert property (p_cfg_mask)
      else $error("undefined control bits were stored");
endmodule // psgar_regs
